//--- hdl/sysclk_bias_xo_config_regs.sv
// Behaviour
// RL1: Five-bit read-write divide integer in divider register low bits, resets to twelve.
// RL2: System clock is analog loop VCO over four, divided by the integer.
// RL3: Software programs the divide integer only from ten to fifteen.
// RL4: Software keeps the system clock between 180 and 333 MHz.
// RL5: Software should aim for a system clock of 210 to 240 MHz.
// RL6: Changing the divide integer requires recomputing signal loss monitor counts.
// RL7: Status bit 0 reads zero while calibrating, one when calibration is done.
// RL8: Status bit 1 shows calibration failure, meaningful once done.
// RL9: Status bits 4 to 2 show the setting chosen by calibration.
// RL10: Status bits 7 to 5 show the setting delivered to the bias circuit.
// RL11: Status bit 8 shows the raw calibration comparator output.
// RL12: Control bit 16 enables the crystal regulator; resets to one.
// RL13: Control bits 15 to 14 enable zero to three gain-boost amplifiers; reset one.
// RL14: Software preserves reserved control fields with read-modify-write.
// RL15: Software polls the done bit before trusting calibration results.
module sysclk_bias_xo_config_regs (
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  input  wire sysclk_cfg_pkg::avalon_req_type avmReq,
  output logic [31:0]                         readdata,
  output logic                                waitrequest,
  input  wire sysclk_cfg_pkg::bias_cal_type   biasCalIn,
  input  wire logic                           vcoQuarterTick,
  output logic                                sysClkTick,
  output logic [4:0]                          sysDivideInt,
  output logic                                crystalRegulatorOn,
  output logic [2:0]                          gainAmpEnable,
  output logic [1:0]                          crystalSpareBits,
  output logic                                divChangedFlag
);
  import sysclk_cfg_pkg::*;

  cfg_state_type s_r;
  cfg_state_type s_nxt;
  logic [31:0]   laneMask;
  logic [31:0]   divWord;
  logic [31:0]   xoWord;
  logic [31:0]   mergedDiv;
  logic [31:0]   mergedXo;
  logic          divWrite;
  logic          xoWrite;
  logic          eventWrite;

  localparam cfg_state_type STATE_RESET = '{
    busState:   BUS_IDLE,
    waitReq:    1'b1,
    readData:   32'h0000_0000,
    divideInt:  DIV_RESET,
    xo:         XO_RESET,
    divChanged: 1'b0,
    bias:       '0,
    gainAmps:   3'h1
  };

  // Thermometer code: value n turns on n parallel amplifiers.
  function automatic logic [2:0] amp_enables(input logic [1:0] count);
    logic [2:0] result;
    result = 3'h0;
    case (count)
      2'h0:    result = 3'h0;
      2'h1:    result = 3'h1;
      2'h2:    result = 3'h3;
      2'h3:    result = 3'h7;
      default: result = 3'h0;
    endcase
    return result;
  endfunction

  function automatic logic [31:0] bias_word(input bias_cal_type b);
    logic [31:0] w;
    w                                    = 32'h0000_0000;
    w[CAL_DONE_BIT]                      = b.done; // RL7
    w[CAL_FAIL_BIT]                      = b.fail; // RL8
    w[CAL_SET_LSB +: CAL_SET_W]          = b.setting; // RL9
    w[CAL_EFF_LSB +: CAL_SET_W]          = b.effSetting; // RL10
    w[CAL_CMP_BIT]                       = b.comparator; // RL11
    return w;
  endfunction

  // Byte enables widen into a bit mask for read-modify-write merging.
  for (genvar i = 0; i < 4; i++) begin : gLane
    assign laneMask[8*i +: 8] = {8{avmReq.byteenable[i]}};
  end

  always_comb begin
    divWord                    = 32'h0000_0000;
    divWord[DIV_LSB +: DIV_W]  = s_r.divideInt;
    xoWord                     = 32'h0000_0000;
    xoWord[XO_W-1:0]           = s_r.xo;
  end

  assign mergedDiv = (divWord & ~laneMask) | (avmReq.writedata & laneMask);
  assign mergedXo  = (xoWord & ~laneMask) | (avmReq.writedata & laneMask);

  // Writes take effect at the edge where waitrequest is seen low.
  assign divWrite   = (s_r.busState == BUS_ACK) && avmReq.write && (avmReq.address == DIV_OFFSET);
  assign xoWrite    = (s_r.busState == BUS_ACK) && avmReq.write && (avmReq.address == XO_OFFSET);
  assign eventWrite = (s_r.busState == BUS_ACK) && avmReq.write
                      && (avmReq.address == EVENT_OFFSET);

  always_comb begin
    s_nxt          = s_r;
    s_nxt.bias     = biasCalIn; // RL7
    s_nxt.gainAmps = amp_enables(s_r.xo.gainBoost); // RL13

    if (divWrite) begin
      s_nxt.divideInt = mergedDiv[DIV_LSB +: DIV_W]; // RL1
    end
    if (xoWrite) begin
      s_nxt.xo = mergedXo[XO_W-1:0]; // RL12
    end

    // Write-one-to-clear, but a fresh change of divide integer wins.
    if (eventWrite && avmReq.byteenable[0] && avmReq.writedata[DIV_CHG_BIT]) begin
      s_nxt.divChanged = 1'b0;
    end
    if (divWrite && mergedDiv[DIV_LSB +: DIV_W] != s_r.divideInt) begin
      s_nxt.divChanged = 1'b1; // RL6
    end

    case (s_r.busState)
      BUS_IDLE: begin
        s_nxt.waitReq = 1'b1;
        if (avmReq.read || avmReq.write) begin
          s_nxt.busState = BUS_ACK;
          s_nxt.waitReq  = 1'b0;
          s_nxt.readData = 32'h0000_0000;
          if (avmReq.read) begin
            case (avmReq.address)
              DIV_OFFSET:   s_nxt.readData = divWord; // RL1
              BIAS_OFFSET:  s_nxt.readData = bias_word(s_r.bias); // RL8
              XO_OFFSET:    s_nxt.readData = xoWord; // RL12
              EVENT_OFFSET: s_nxt.readData = {31'h0, s_r.divChanged};
              default:      s_nxt.readData = 32'h0000_0000;
            endcase
          end
        end
      end
      BUS_ACK: begin
        s_nxt.busState = BUS_IDLE;
        s_nxt.waitReq  = 1'b1;
      end
      default: begin
        s_nxt.busState = BUS_IDLE;
        s_nxt.waitReq  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  sysclk_divider uDivider (
    .mclk           (mclk),
    .arst_n         (arst_n),
    .vcoQuarterTick (vcoQuarterTick),
    .divideInt      (s_r.divideInt),
    .sysClkTick     (sysClkTick)
  );

  assign readdata           = s_r.readData;
  assign waitrequest        = s_r.waitReq;
  assign sysDivideInt       = s_r.divideInt;
  assign crystalRegulatorOn = s_r.xo.crystalRegulatorOn;
  assign gainAmpEnable      = s_r.gainAmps;
  assign crystalSpareBits   = s_r.xo.crystalSpareBits;
  assign divChangedFlag     = s_r.divChanged;

  logic idleRead;
  assign idleRead = (s_r.busState == BUS_IDLE) && avmReq.read;

  property p_div_write;
    @(posedge mclk) disable iff (!arst_n)
      (divWrite && avmReq.byteenable[0]) |=> (sysDivideInt == $past(avmReq.writedata[4:0]));
  endproperty
  a_div_write: assert property (p_div_write) else $error("Divide integer not written."); // RL1

  property p_div_readback;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == DIV_OFFSET)
      |=> (readdata == {27'h0, $past(sysDivideInt)}) && !waitrequest;
  endproperty
  a_div_readback: assert property (p_div_readback) else $error("Divide readback wrong."); // RL1

  property p_div_change_flag;
    @(posedge mclk) disable iff (!arst_n)
      (divWrite && avmReq.byteenable[0] && avmReq.writedata[4:0] != sysDivideInt)
      |=> divChangedFlag;
  endproperty
  a_div_change_flag: assert property (p_div_change_flag) else $error("Change flag missed."); // RL6

  property p_cal_done;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == BIAS_OFFSET) ##1 1'b1
      |-> readdata[CAL_DONE_BIT] == $past(biasCalIn.done, 2);
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("Done bit wrong."); // RL7

  property p_cal_fail;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == BIAS_OFFSET)
      |=> readdata[CAL_FAIL_BIT] == $past(biasCalIn.fail, 2);
  endproperty
  a_cal_fail: assert property (p_cal_fail) else $error("Fail bit wrong."); // RL8

  property p_cal_setting;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == BIAS_OFFSET)
      |=> readdata[4:2] == $past(biasCalIn.setting, 2);
  endproperty
  a_cal_setting: assert property (p_cal_setting) else $error("Chosen setting wrong."); // RL9

  property p_cal_eff;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == BIAS_OFFSET)
      |=> readdata[7:5] == $past(biasCalIn.effSetting, 2);
  endproperty
  a_cal_eff: assert property (p_cal_eff) else $error("Delivered setting wrong."); // RL10

  property p_cal_cmp;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == BIAS_OFFSET)
      |=> readdata[CAL_CMP_BIT] == $past(biasCalIn.comparator, 2) && readdata[15:9] == 7'h00;
  endproperty
  a_cal_cmp: assert property (p_cal_cmp) else $error("Comparator bit wrong."); // RL11

  property p_regulator;
    @(posedge mclk) disable iff (!arst_n)
      (xoWrite && avmReq.byteenable[2]) |=> crystalRegulatorOn == $past(avmReq.writedata[16]);
  endproperty
  a_regulator: assert property (p_regulator) else $error("Regulator enable wrong."); // RL12

  property p_gain_amps;
    @(posedge mclk) disable iff (!arst_n)
      (xoWrite && avmReq.byteenable[1])
      |=> ##1 ($countones(gainAmpEnable) == $past(avmReq.writedata[15:14], 2))
              && (gainAmpEnable[0] || gainAmpEnable == 3'h0);
  endproperty
  a_gain_amps: assert property (p_gain_amps) else $error("Amplifier count wrong."); // RL13

  property p_bus_answer;
    @(posedge mclk) disable iff (!arst_n)
      ((s_r.busState == BUS_IDLE) && (avmReq.read || avmReq.write))
      |=> !waitrequest ##1 waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("Bus answer timing wrong.");

  // High in a cycle where the slave accepts a new request at the coming edge.
  logic takeReq;
  assign takeReq = (s_r.busState == BUS_IDLE) && (avmReq.read || avmReq.write);

  property p_xo_readback;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == XO_OFFSET)
      |=> readdata[16] == $past(crystalRegulatorOn)
          && readdata[18:17] == $past(crystalSpareBits)
          && readdata[31:XO_W] == 13'h0;
  endproperty
  a_xo_readback: assert property (p_xo_readback) else $error("Crystal readback wrong."); // RL12

  property p_gain_code;
    @(posedge mclk) disable iff (!arst_n)
      1'b1 |-> gainAmpEnable == 3'h0 || gainAmpEnable == 3'h1 || gainAmpEnable == 3'h3
               || gainAmpEnable == 3'h7;
  endproperty
  a_gain_code: assert property (p_gain_code) else $error("Enables not thermometer."); // RL13

  property p_gain_follow;
    @(posedge mclk) disable iff (!arst_n)
      1'b1 |=> $countones(gainAmpEnable) == $past(s_r.xo.gainBoost);
  endproperty
  a_gain_follow: assert property (p_gain_follow) else $error("Enables lag field."); // RL13

  property p_unmapped_read;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address != DIV_OFFSET && avmReq.address != BIAS_OFFSET
       && avmReq.address != XO_OFFSET && avmReq.address != EVENT_OFFSET)
      |=> readdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero.");

  property p_write_clears_data;
    @(posedge mclk) disable iff (!arst_n)
      (takeReq && avmReq.write) |=> readdata == 32'h0000_0000;
  endproperty
  a_write_clears_data: assert property (p_write_clears_data) else $error("Write answer not zero.");

  property p_read_stands;
    @(posedge mclk) disable iff (!arst_n)
      !takeReq |=> $stable(readdata);
  endproperty
  a_read_stands: assert property (p_read_stands) else $error("Read data moved while idle.");

  property p_div_hold;
    @(posedge mclk) disable iff (!arst_n)
      !divWrite |=> $stable(sysDivideInt);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("Divide integer moved unwritten."); // RL1

  property p_xo_hold;
    @(posedge mclk) disable iff (!arst_n)
      !xoWrite |=> $stable(crystalRegulatorOn) && $stable(crystalSpareBits);
  endproperty
  a_xo_hold: assert property (p_xo_hold) else $error("Crystal control moved unwritten."); // RL12

  property p_flag_clear;
    @(posedge mclk) disable iff (!arst_n)
      (eventWrite && avmReq.byteenable[0] && avmReq.writedata[DIV_CHG_BIT]) |=> !divChangedFlag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Change flag not cleared."); // RL6

  property p_flag_hold;
    @(posedge mclk) disable iff (!arst_n)
      (!eventWrite && !divWrite) |=> $stable(divChangedFlag);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("Change flag moved alone."); // RL6

  property p_flag_quiet;
    @(posedge mclk) disable iff (!arst_n)
      (divWrite && !avmReq.byteenable[0] && !divChangedFlag) |=> !divChangedFlag;
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) else $error("Change flag set without change."); // RL6

  property p_event_readback;
    @(posedge mclk) disable iff (!arst_n)
      (idleRead && avmReq.address == EVENT_OFFSET) |=> readdata == {31'h0, $past(divChangedFlag)};
  endproperty
  a_event_readback: assert property (p_event_readback) else $error("Event readback wrong."); // RL6

  property p_wait_single;
    @(posedge mclk) disable iff (!arst_n)
      !waitrequest |=> waitrequest;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("Wait request low too long.");

  property p_ack_after_request;
    @(posedge mclk) disable iff (!arst_n)
      $fell(waitrequest) |-> $past(takeReq);
  endproperty
  a_ack_after_request: assert property (p_ack_after_request) else $error("Answer without request.");

endmodule

//--- hdl/sysclk_cfg_pkg.sv
package sysclk_cfg_pkg;

  // Register byte addresses on the Avalon-MM slave.
  localparam logic [3:0] DIV_OFFSET   = 4'h0;
  localparam logic [3:0] BIAS_OFFSET  = 4'h4;
  localparam logic [3:0] XO_OFFSET    = 4'h8;
  localparam logic [3:0] EVENT_OFFSET = 4'hc;

  // System clock divider register.
  localparam int         DIV_LSB   = 0;
  localparam int         DIV_W     = 5;
  localparam logic [4:0] DIV_RESET = 5'h0c;

  // Bias calibration status register.
  localparam int CAL_DONE_BIT = 0;
  localparam int CAL_FAIL_BIT = 1;
  localparam int CAL_SET_LSB  = 2;
  localparam int CAL_EFF_LSB  = 5;
  localparam int CAL_CMP_BIT  = 8;
  localparam int CAL_SET_W    = 3;

  // Event register: divide integer changed, write one to clear.
  localparam int DIV_CHG_BIT = 0;

  // Crystal oscillator control occupies bits 18:0 in this field order.
  localparam int XO_W = 19;

  typedef struct packed {
    logic [1:0] crystalSpareBits;
    logic       crystalRegulatorOn;
    logic [1:0] gainBoost;
    logic [5:0] reservedHigh;
    logic [1:0] reservedMid;
    logic [5:0] reservedLow;
  } xo_ctrl_type;

  localparam xo_ctrl_type XO_RESET = '{
    crystalSpareBits:   2'h0,
    crystalRegulatorOn: 1'h1,
    gainBoost:          2'h1,
    reservedHigh:       6'h1f,
    reservedMid:        2'h0,
    reservedLow:        6'h1f
  };

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avalon_req_type;

  typedef struct packed {
    logic       done;
    logic       fail;
    logic [2:0] setting;
    logic [2:0] effSetting;
    logic       comparator;
  } bias_cal_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_type;

  typedef struct packed {
    bus_state_type busState;
    logic          waitReq;
    logic [31:0]   readData;
    logic [4:0]    divideInt;
    xo_ctrl_type   xo;
    logic          divChanged;
    bias_cal_type  bias;
    logic [2:0]    gainAmps;
  } cfg_state_type;

  typedef struct packed {
    logic [4:0] count;
    logic       tick;
  } div_state_type;

endpackage

//--- hdl/sysclk_divider.sv
module sysclk_divider (
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       vcoQuarterTick,
  input  wire logic [4:0] divideInt,
  output logic            sysClkTick
);
  import sysclk_cfg_pkg::*;

  div_state_type s_r;
  div_state_type s_nxt;
  logic [4:0]    lastIdx;

  // A divide of zero or one degenerates to passing every tick through.
  assign lastIdx = (divideInt <= 5'h01) ? 5'h00 : divideInt - 5'h01;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (vcoQuarterTick) begin
      if (s_r.count >= lastIdx) begin // RL2
        s_nxt.count = 5'h00;
        s_nxt.tick  = 1'b1;
      end else begin
        s_nxt.count = s_r.count + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sysClkTick = s_r.tick;

  // Helper: quarter-rate ticks seen since the last output tick.
  logic [5:0] tickCount;
  logic [4:0] divAtLast;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tickCount <= 6'h00;
      divAtLast <= 5'h00;
    end else if (s_r.tick) begin
      tickCount <= {5'h00, vcoQuarterTick};
      divAtLast <= divideInt;
    end else if (vcoQuarterTick) begin
      tickCount <= tickCount + 6'h01;
    end
  end

  property p_divide_ratio;
    @(posedge mclk) disable iff (!arst_n)
      (s_r.tick && divAtLast == divideInt && divideInt > 5'h01 && $past(s_r.tick) == 1'b0
       && tickCount != 6'h00 && $past(tickCount) != 6'h00)
      |-> (tickCount == {1'b0, divideInt});
  endproperty
  a_divide_ratio: assert property (p_divide_ratio) else $error("System tick spacing wrong."); // RL2

endmodule

//--- sim/sysclk_bias_xo_config_regs_test.sv
module sysclk_bias_xo_config_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sysclk_cfg_pkg::*;

  logic           mclk        = 1'b0;
  logic           arst_n      = 1'b0;
  avalon_req_type req         = '0;
  bias_cal_type   biasCal     = '0;
  logic           vcoTick     = 1'b0;
  logic [31:0]    readdata;
  logic           waitrequest;
  logic           sysClkTick;
  logic [4:0]     sysDivideInt;
  logic           regOn;
  logic [2:0]     gainAmps;
  logic [1:0]     spare;
  logic           divChg;
  logic [31:0]    rd;
  logic [8:0]     b;
  int             failCount   = 0;
  int             comparisons = 0;
  int             seed        = 32'h2a87a16b;
  int             divM        = 12;
  int             xoM         = 32'h0001_5f1f;
  int             chgM        = 0;
  int             v;

  always #2 mclk = ~mclk;

  sysclk_bias_xo_config_regs i_sysclk_bias_xo_config_regs (
    .mclk               (mclk),
    .arst_n             (arst_n),
    .avmReq             (req),
    .readdata           (readdata),
    .waitrequest        (waitrequest),
    .biasCalIn          (biasCal),
    .vcoQuarterTick     (vcoTick),
    .sysClkTick         (sysClkTick),
    .sysDivideInt       (sysDivideInt),
    .crystalRegulatorOn (regOn),
    .gainAmpEnable      (gainAmps),
    .crystalSpareBits   (spare),
    .divChangedFlag     (divChg)
  );

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One Avalon transfer; the request is held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    n = 0;
    req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: be};
    @(posedge mclk);
    while (waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) check("waitrequest", 32'h0, {31'h0, waitrequest});
    q = readdata;
    req <= '0;
    @(posedge mclk);
  endtask

  function automatic int merge(input int old, input logic [31:0] d, input logic [3:0] be);
    for (int k = 0; k < 4; k++) begin
      if (be[k]) old[8*k+:8] = d[8*k+:8];
    end
    return old;
  endfunction

  task automatic pins;
    @(posedge mclk);
    check("sysDivideInt", divM, {27'h0, sysDivideInt});
    check("regulator", xoM[16], {31'h0, regOn});
    check("gainAmps", (1 << xoM[15:14]) - 1, {29'h0, gainAmps});
    check("spare", xoM[18:17], {30'h0, spare});
    check("divChanged", chgM, {31'h0, divChg});
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int w;
    bus(1'b1, a, d, be, rd);
    w = merge(a == 4'h0 ? divM : xoM, d, be);
    if (a == 4'h0) begin
      if ((w & 'h1f) != divM) chgM = 1;
      divM = w & 'h1f;
    end else if (a == 4'h8) begin
      xoM = w & 'h7ffff;
    end else if (a == 4'hc && be[0] && d[0]) begin
      chgM = 0;
    end
    pins();
  endtask

  task automatic rdchk(input logic [3:0] a, input string name);
    bus(1'b0, a, 32'h0, 4'h0, rd);
    check(name, a == 4'h0 ? divM : a == 4'h8 ? xoM : a == 4'hc ? chgM : 0, rd);
  endtask

  // Locks onto a divider pulse, then follows random input ticks one edge at a time.
  task automatic ticks;
    int   m;
    int   n;
    logic expT;
    n = 0;
    vcoTick <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (sysClkTick !== 1'b1 && n < 40);
    check("tickSync", 32'h1, {31'h0, sysClkTick});
    m = 1;
    expT = 1'b0;
    repeat (80) begin
      vcoTick <= 1'($random(seed));
      @(posedge mclk);
      check("sysClkTick", {31'h0, expT}, {31'h0, sysClkTick});
      expT = 1'b0;
      if (vcoTick) begin
        m++;
        if (m >= divM) begin
          m = 0;
          expT = 1'b1;
        end
      end
    end
    vcoTick <= 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    pins();
    rdchk(4'h0, "divider");
    rdchk(4'h8, "xoControl");
    rdchk(4'hc, "event");
    ticks();
    $display("test reset done");
    repeat (6) begin
      v = 10 + ($unsigned($random(seed)) % 6);
      wr(4'h0, v, 4'hf);
      rdchk(4'h0, "divider");
      ticks();
      rdchk(4'hc, "event");
      wr(4'hc, 32'h1, 4'h1);
    end
    wr(4'h0, 32'h0b, 4'h0);
    wr(4'h0, divM, 4'hf);
    $display("test divider done");
    for (int i = 0; i < 8; i++) begin
      b = 9'($random(seed));
      b[8] = i[0];
      biasCal <= b;
      repeat (3) @(posedge mclk);
      bus(1'b0, 4'h4, 32'h0, 4'h0, rd);
      check("bias", {23'h0, b[0], b[3:1], b[6:4], b[7], b[8]}, rd);
    end
    // Calibration runs, then completes; results are checked only once done is seen.
    biasCal <= 9'h0ff;
    repeat (3) @(posedge mclk);
    v = 0;
    do begin
      if (v == 4) biasCal <= 9'h1ff;
      bus(1'b0, 4'h4, 32'h0, 4'h0, rd);
      v++;
    end while (rd[0] !== 1'b1 && v < 20);
    check("biasPolled", 32'h0000_01ff, rd);
    $display("test bias done");
    for (int g = 0; g < 4; g++) begin
      bus(1'b0, 4'h8, 32'h0, 4'h0, rd);
      wr(4'h8, (rd & ~32'h7c000) | (g << 14) | ((g & 1) << 16) | (g << 17), 4'hf);
      rdchk(4'h8, "xoControl");
    end
    $display("test crystal done");
    wr(4'h2, 32'hffff_ffff, 4'hf);
    rdchk(4'h2, "unmapped");
    rdchk(4'h0, "divider");
    rdchk(4'h8, "xoControl");
    $display("test unmapped done");
    giveVerdict();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failCount++;
    giveVerdict();
  end
endmodule
